// File: lkes_legacy_kbd_emulation_status.sv
// module: legacy keyboard emulation status, data registers, interrupt conditions
`timescale 1ns/1ps
module lkes_legacy_kbd_emulation_status
(
    input wire logic clock_i,
    input wire logic reset_i,
    // memory-mapped operational access by emulation software
    input wire logic mem_sel_i,
    input wire logic mem_write_i,
    input wire logic [11:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic [31:0] mem_rdata_o,
    // legacy I/O access by host software
    input wire logic io_sel_i,
    input wire logic io_write_i,
    input wire logic [7:0] io_port_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // controls and conditions
    input wire logic emulation_enable_i,
    input wire logic char_pending_i,
    input wire logic legacy_irq_enable_i,
    input wire logic gate_a20_seq_i,
    input wire logic parity_error_i,
    input wire logic timeout_i,
    input wire logic keyboard_inhibit_state_i,
    output logic emulation_irq_o,
    output logic mouse_interrupt_line_o,
    output logic keyboard_interrupt_line_o
);
    import lkes_pkg::*;

    // ====================================================================
    // decode helpers
    // one compare per kind keeps the read mux and the write strobes in step
    function automatic logic port_is(input logic [7:0] port, input logic [7:0] want);
        return port == want;
    endfunction

    function automatic logic offset_is(input logic [11:0] addr, input logic [11:0] want);
        return addr == want;
    endfunction

    // ====================================================================
    // declarations
    logic [7:0] status;
    logic [7:0] legacy_emulation_input;
    logic [7:0] legacy_emulation_output;
    logic [7:0] next_legacy_emulation_input;
    logic [7:0] next_legacy_emulation_output;
    logic [7:0] next_io_rdata;
    logic [7:0] mem_rd_byte;

    // decode strobes
    logic io_active;
    logic io_rd;
    logic io_wr;
    logic at_data_port;
    logic at_cmd_port;
    logic at_status_ofs;
    logic at_input_ofs;
    logic at_output_ofs;
    logic mem_wr;
    logic port_wr_data;
    logic port_wr_cmd;
    logic port_wr_any;
    logic port_rd_data;
    logic port_rd_cmd;
    logic mem_wr_status;
    logic mem_wr_input;
    logic mem_wr_output;

    // interrupt terms
    logic in_full;
    logic out_full;
    logic aux_full;
    logic emu_from_input;
    logic emu_from_output;
    logic host_irq_armed;

    // ====================================================================
    // legacy I/O decode
    // legacy ports are only claimed while emulation is on
    assign io_active = io_sel_i & emulation_enable_i;
    assign io_rd = io_active & ~io_write_i;
    assign io_wr = io_active & io_write_i;
    assign at_data_port = port_is(io_port_i, LKES_PORT_DATA);
    assign at_cmd_port = port_is(io_port_i, LKES_PORT_CMD);
    assign port_wr_data = io_wr & at_data_port;
    assign port_wr_cmd = io_wr & at_cmd_port;
    assign port_wr_any = port_wr_data | port_wr_cmd;
    assign port_rd_data = io_rd & at_data_port;
    assign port_rd_cmd = io_rd & at_cmd_port;

    // ====================================================================
    // memory-mapped decode
    // strobes only: a memory access never raises a condition by itself
    assign mem_wr = mem_sel_i & mem_write_i;
    assign at_status_ofs = offset_is(mem_addr_i, LKES_OFS_STATUS);
    assign at_input_ofs = offset_is(mem_addr_i, LKES_OFS_INPUT);
    assign at_output_ofs = offset_is(mem_addr_i, LKES_OFS_OUTPUT);
    assign mem_wr_status = mem_wr & at_status_ofs;
    assign mem_wr_input = mem_wr & at_input_ofs;
    assign mem_wr_output = mem_wr & at_output_ofs;

    // ====================================================================
    // read paths
    // unmapped offsets read as zero; reserved upper bits always zero
    always_comb
    begin
        if (at_status_ofs)
        begin
            mem_rd_byte = status;
        end
        else if (at_input_ofs)
        begin
            mem_rd_byte = legacy_emulation_input;
        end
        else if (at_output_ofs)
        begin
            mem_rd_byte = legacy_emulation_output;
        end
        else
        begin
            mem_rd_byte = 8'h00;
        end
    end
    assign mem_rdata_o = {24'h000000, mem_rd_byte};

    // byte held until the next legacy read, so a slow host still sees it
    always_comb
    begin
        if (port_rd_cmd)
        begin
            next_io_rdata = status;
        end
        else if (port_rd_data)
        begin
            next_io_rdata = legacy_emulation_output;
        end
        else
        begin
            next_io_rdata = io_rdata_o;
        end
    end

    // ====================================================================
    // flags
    // every side effect on the status bits lives in the flag module
    lkes_status_flags u_flags
    (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .sw_write_i(mem_wr_status),
        .sw_wdata_i(mem_wdata_i[7:0]),
        .port_wr_data_i(port_wr_data),
        .port_wr_cmd_i(port_wr_cmd),
        .port_rd_data_i(port_rd_data),
        .gate_a20_seq_i(gate_a20_seq_i),
        .parity_error_i(parity_error_i),
        .timeout_i(timeout_i),
        .keyboard_inhibit_state_i(keyboard_inhibit_state_i),
        .status_o(status)
    );

    // ====================================================================
    // data registers
    // a port write beats a same-cycle memory write: the host byte is never lost
    assign next_legacy_emulation_input = port_wr_any ? io_wdata_i :
                                         mem_wr_input ? mem_wdata_i[7:0] : legacy_emulation_input;
    assign next_legacy_emulation_output = mem_wr_output ? mem_wdata_i[7:0] : legacy_emulation_output;

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            legacy_emulation_input <= LKES_DATA_RESET;
        end
        else
        begin
            legacy_emulation_input <= next_legacy_emulation_input;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            legacy_emulation_output <= LKES_DATA_RESET;
        end
        else
        begin
            legacy_emulation_output <= next_legacy_emulation_output;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            io_rdata_o <= LKES_DATA_RESET;
        end
        else
        begin
            io_rdata_o <= next_io_rdata;
        end
    end

    // ====================================================================
    // interrupt conditions, level outputs
    assign in_full = status[LKES_B_IN_FULL];
    assign out_full = status[LKES_B_OUT_FULL];
    assign aux_full = status[LKES_B_AUX_FULL];
    assign emu_from_input = in_full & emulation_enable_i;
    // not gated by the enable: emulation software owns the character-pending control
    assign emu_from_output = ~out_full & char_pending_i;
    assign emulation_irq_o = emu_from_input | emu_from_output;

    // aux flag steers the one shared enable to the mouse or the keyboard line
    assign host_irq_armed = out_full & legacy_irq_enable_i;
    assign mouse_interrupt_line_o = host_irq_armed & aux_full;
    assign keyboard_interrupt_line_o = host_irq_armed & ~aux_full;
endmodule // lkes_legacy_kbd_emulation_status

// File: lkes_pkg.sv
// package: offsets, status field positions and reset values for legacy keyboard emulation
// ====================================================================
// What this block does
// - with emulation on, keyboard status port read returns the status register.
// - memory-mapped status access stores or returns value only, no side effects.
// - bit 3 cleared by data port write, set by command port write.
// - bit 1 set by any port write, unchanged during a gate A20 sequence.
// - emulation interrupt while bit 1 is set and emulation is on.
// - bit 0 cleared by a host read of the data port.
// - emulation interrupt while bit 0 is clear and character-pending control is set.
// - mouse interrupt when aux flag, bit 0 and IRQ enable all set.
// - bit 7 shows a parity error on keyboard or mouse data.
// - bit 6 shows a time-out in the emulated keyboard interface.
// - bit 4 reflects keyboard inhibit switch; one means keyboard active.
// - input data register captures bytes written to data or command port.
// - with emulation on, data port read returns the output data register.
package lkes_pkg;
    // ====================================================================
    // offsets
    localparam logic [11:0] LKES_OFS_INPUT = 12'h104;
    localparam logic [11:0] LKES_OFS_OUTPUT = 12'h108;
    localparam logic [11:0] LKES_OFS_STATUS = 12'h10c;
    localparam logic [7:0] LKES_PORT_DATA = 8'h60;
    localparam logic [7:0] LKES_PORT_CMD = 8'h64;
    // ====================================================================
    // status fields
    localparam int LKES_B_OUT_FULL = 0;
    localparam int LKES_B_IN_FULL = 1;
    localparam int LKES_B_FLAG = 2;
    localparam int LKES_B_CMD_DATA = 3;
    localparam int LKES_B_INHIBIT = 4;
    localparam int LKES_B_AUX_FULL = 5;
    localparam int LKES_B_TIMEOUT = 6;
    localparam int LKES_B_PARITY = 7;
    localparam logic [7:0] LKES_STATUS_RESET = 8'h00;
    localparam logic [7:0] LKES_DATA_RESET = 8'h00;
endpackage

// File: lkes_status_flags.sv
// module: the eight status flags and their port side effects
`timescale 1ns/1ps
module lkes_status_flags
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic sw_write_i,
    input wire logic [7:0] sw_wdata_i,
    input wire logic port_wr_data_i,
    input wire logic port_wr_cmd_i,
    input wire logic port_rd_data_i,
    input wire logic gate_a20_seq_i,
    input wire logic parity_error_i,
    input wire logic timeout_i,
    input wire logic keyboard_inhibit_state_i,
    output logic [7:0] status_o
);
    import lkes_pkg::*;

    logic [7:0] status;
    logic [7:0] next_status;
    logic port_wr;

    assign port_wr = port_wr_data_i | port_wr_cmd_i;

    always_comb
    begin
        next_status = status;
        // software store first so hardware events in the same cycle win
        if (sw_write_i)
        begin
            next_status = sw_wdata_i;
        end
        if (port_wr_data_i)
        begin
            next_status[LKES_B_CMD_DATA] = 1'b0;
        end
        if (port_wr_cmd_i)
        begin
            next_status[LKES_B_CMD_DATA] = 1'b1;
        end
        if (port_wr && !gate_a20_seq_i)
        begin
            next_status[LKES_B_IN_FULL] = 1'b1;
        end
        if (port_rd_data_i)
        begin
            next_status[LKES_B_OUT_FULL] = 1'b0;
        end
        if (parity_error_i)
        begin
            next_status[LKES_B_PARITY] = 1'b1;
        end
        if (timeout_i)
        begin
            next_status[LKES_B_TIMEOUT] = 1'b1;
        end
        next_status[LKES_B_INHIBIT] = keyboard_inhibit_state_i;
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            status <= LKES_STATUS_RESET;
        end
        else
        begin
            status <= next_status;
        end
    end

    assign status_o = status;
endmodule // lkes_status_flags

// File: lkes_host_model.sv
// host software side: legacy keyboard I/O port accesses
`timescale 1ns/1ps
module lkes_host_model
(
    input wire logic clock_i,
    input wire logic [7:0] io_rdata_i,
    output logic io_sel_o = 1'b0,
    output logic io_write_o = 1'b0,
    output logic [7:0] io_port_o = 8'h00,
    output logic [7:0] io_wdata_o = 8'h00
);
    // ========
    // access task
    // released data lines flip so a stale byte never looks valid
    task automatic acc(input logic w, input logic [7:0] p, d, output logic [7:0] q);
        @(posedge clock_i);
        {io_sel_o, io_write_o, io_port_o, io_wdata_o} <= {1'b1, w, p, d};
        @(posedge clock_i);
        {io_sel_o, io_wdata_o} <= {1'b0, ~d};
        #1 q = io_rdata_i;
    endtask
endmodule // lkes_host_model

// File: lkes_chk.sv
// checker for the legacy keyboard emulation status block
`timescale 1ns/1ps
module lkes_chk
    import lkes_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic mem_sel_i,
    input wire logic io_sel_i,
    input wire logic io_write_i,
    input wire logic emulation_enable_i,
    input wire logic char_pending_i,
    input wire logic legacy_irq_enable_i,
    input wire logic gate_a20_seq_i,
    input wire logic keyboard_inhibit_state_i,
    input wire logic emulation_irq_o,
    input wire logic mouse_interrupt_line_o,
    input wire logic keyboard_interrupt_line_o,
    input wire logic [11:0] mem_addr_i,
    input wire logic [31:0] mem_rdata_o,
    input wire logic [7:0] io_port_i,
    input wire logic [7:0] io_rdata_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ========
    // status is only visible while the read address points at it
    wire logic st = mem_addr_i == LKES_OFS_STATUS;
    wire logic [7:0] s = mem_rdata_o[7:0];
    wire logic r = io_sel_i && emulation_enable_i && !io_write_i;
    wire logic w = io_sel_i && emulation_enable_i && io_write_i;
    wire logic dp = io_port_i == LKES_PORT_DATA;
    wire logic cp = io_port_i == LKES_PORT_CMD;
    a_status_read: assert property (r && cp && st |=> io_rdata_o == $past(s)) else $error("status read");
    a_cmd_write: assert property (w && cp && !gate_a20_seq_i |=> !st || s[3] && s[1]) else $error("cmd");
    a_data_write: assert property (w && dp |=> !st || !s[3]) else $error("data write");
    a_out_clear: assert property (r && dp |=> !st || !s[0]) else $error("out flag");
    a_emu_irq: assert property
        (st |-> emulation_irq_o == (s[1] && emulation_enable_i || !s[0] && char_pending_i))
        else $error("emulation irq");
    a_mouse_line: assert property
        (st |-> mouse_interrupt_line_o == (s[5] && s[0] && legacy_irq_enable_i))
        else $error("mouse line");
    a_kbd_line: assert property
        (st |-> keyboard_interrupt_line_o == (!s[5] && s[0] && legacy_irq_enable_i))
        else $error("keyboard line");
    // bit 4 follows the switch every cycle, so only bits 3:0 are checked to hold
    a_io_refused: assert property
        (io_sel_i && !emulation_enable_i && !mem_sel_i && st |=> !st || $stable(s[3:0]))
        else $error("io while off");
    a_inhibit_copy: assert property
        (st && $past(st) |-> s[4] == $past(keyboard_inhibit_state_i))
        else $error("inhibit switch");
endmodule // lkes_chk
bind lkes_legacy_kbd_emulation_status lkes_chk u_chk
(
    .clock_i(clock_i),
    .reset_i(reset_i),
    .mem_sel_i(mem_sel_i),
    .io_sel_i(io_sel_i),
    .io_write_i(io_write_i),
    .emulation_enable_i(emulation_enable_i),
    .char_pending_i(char_pending_i),
    .legacy_irq_enable_i(legacy_irq_enable_i),
    .gate_a20_seq_i(gate_a20_seq_i),
    .keyboard_inhibit_state_i(keyboard_inhibit_state_i),
    .emulation_irq_o(emulation_irq_o),
    .mouse_interrupt_line_o(mouse_interrupt_line_o),
    .keyboard_interrupt_line_o(keyboard_interrupt_line_o),
    .mem_addr_i(mem_addr_i),
    .mem_rdata_o(mem_rdata_o),
    .io_port_i(io_port_i),
    .io_rdata_o(io_rdata_o)
);

// File: lkes_legacy_kbd_emulation_status_tb_top.sv
// self-checking bench for the legacy keyboard emulation status block
`timescale 1ns/1ps
module lkes_legacy_kbd_emulation_status_tb_top;
    import lkes_pkg::*;
    logic clock_i, reset_i, mem_sel_i, mem_write_i, io_sel_i, io_write_i, emulation_enable_i, char_pending_i;
    logic legacy_irq_enable_i, gate_a20_seq_i, parity_error_i, timeout_i, keyboard_inhibit_state_i;
    logic emulation_irq_o, mouse_interrupt_line_o, keyboard_interrupt_line_o;
    logic [11:0] mem_addr_i;
    logic [31:0] mem_wdata_i, mem_rdata_o;
    logic [7:0] io_port_i, io_wdata_i, io_rdata_o, q;
    int failures, cmp_count;
    wire logic [31:0] lines = {29'h0, emulation_irq_o, mouse_interrupt_line_o, keyboard_interrupt_line_o};
    lkes_legacy_kbd_emulation_status uut
    (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .mem_sel_i(mem_sel_i),
        .mem_write_i(mem_write_i),
        .mem_addr_i(mem_addr_i),
        .mem_wdata_i(mem_wdata_i),
        .mem_rdata_o(mem_rdata_o),
        .io_sel_i(io_sel_i),
        .io_write_i(io_write_i),
        .io_port_i(io_port_i),
        .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o),
        .emulation_enable_i(emulation_enable_i),
        .char_pending_i(char_pending_i),
        .legacy_irq_enable_i(legacy_irq_enable_i),
        .gate_a20_seq_i(gate_a20_seq_i),
        .parity_error_i(parity_error_i),
        .timeout_i(timeout_i),
        .keyboard_inhibit_state_i(keyboard_inhibit_state_i),
        .emulation_irq_o(emulation_irq_o),
        .mouse_interrupt_line_o(mouse_interrupt_line_o),
        .keyboard_interrupt_line_o(keyboard_interrupt_line_o)
    );
    lkes_host_model host (.clock_i(clock_i), .io_rdata_i(io_rdata_o), .io_sel_o(io_sel_i),
        .io_write_o(io_write_i), .io_port_o(io_port_i), .io_wdata_o(io_wdata_i));
    // ========
    // tasks
    task automatic chk(input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic mr(input logic [31:0] e, input logic [11:0] a = LKES_OFS_STATUS);
        @(posedge clock_i);
        {mem_sel_i, mem_write_i, mem_addr_i} <= {2'b10, a};
        @(negedge clock_i);
        chk(mem_rdata_o, e);
        @(posedge clock_i);
        mem_sel_i <= 1'b0;
    endtask
    task automatic mw(input logic [31:0] d, input logic [11:0] a = LKES_OFS_STATUS);
        @(posedge clock_i);
        {mem_sel_i, mem_write_i, mem_addr_i, mem_wdata_i} <= {2'b11, a, d};
        @(posedge clock_i);
        {mem_sel_i, mem_wdata_i} <= {1'b0, ~d};
    endtask
    task automatic conclude();
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    initial
    begin
        #100000;
        failures++;
        conclude();
    end
    initial
    begin
        {reset_i, emulation_enable_i, legacy_irq_enable_i, mem_sel_i, mem_write_i} = 5'h1c;
        {char_pending_i, gate_a20_seq_i, parity_error_i, timeout_i, keyboard_inhibit_state_i} = 5'h0;
        {mem_addr_i, mem_wdata_i} = {LKES_OFS_STATUS, 32'h0};
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        mr(32'h0);
        mr(32'h0, 12'h110);
        mw(32'ha5, LKES_OFS_OUTPUT);
        mw(32'h05);
        @(negedge clock_i) chk(lines, 32'h1);
        mw(32'h25);
        @(negedge clock_i) chk(lines, 32'h2);
        mr(32'h25);
        host.acc(1'b0, LKES_PORT_CMD, 8'h00, q);
        chk({24'h0, q}, 32'h25);
        host.acc(1'b0, LKES_PORT_DATA, 8'h00, q);
        chk({24'h0, q}, 32'ha5);
        @(posedge clock_i) char_pending_i <= 1'b1;
        mr(32'h24);
        @(negedge clock_i) chk(lines, 32'h4);
        @(posedge clock_i) char_pending_i <= 1'b0;
        host.acc(1'b1, LKES_PORT_CMD, 8'h5a, q);
        mr(32'h5a, LKES_OFS_INPUT);
        mr(32'h2e);
        @(negedge clock_i) chk(lines, 32'h4);
        host.acc(1'b1, LKES_PORT_DATA, 8'h33, q);
        mr(32'h26);
        mw(32'h0);
        @(posedge clock_i) gate_a20_seq_i <= 1'b1;
        host.acc(1'b1, LKES_PORT_DATA, 8'h77, q);
        mr(32'h0);
        @(negedge clock_i) chk(lines, 32'h0);
        @(posedge clock_i) {gate_a20_seq_i, emulation_enable_i} <= 2'b00;
        host.acc(1'b1, LKES_PORT_CMD, 8'h11, q);
        mr(32'h77, LKES_OFS_INPUT);
        mr(32'h0);
        @(posedge clock_i) {parity_error_i, timeout_i, keyboard_inhibit_state_i} <= 3'h7;
        @(posedge clock_i) {parity_error_i, timeout_i} <= 2'b00;
        mr(32'hd0);
        conclude();
    end
endmodule // lkes_legacy_kbd_emulation_status_tb_top
